// >>> hw/rct_pkg.sv
// Shared constants and types for the receive clock and data timing block.
// Assumes one 100 MHz system clock; the reference clock is modelled as enable ticks.
package rct_pkg;
    // System clock and modelled reference clock
    localparam int unsigned RCT_CLK_FREQ_KHZ = 100000;
    localparam int unsigned RCT_REF_FREQ_KHZ = 3125;
    localparam int unsigned RCT_BASE_PER_REF = 8;
    localparam int unsigned RCT_BASE_DIV = RCT_CLK_FREQ_KHZ / (RCT_REF_FREQ_KHZ * RCT_BASE_PER_REF);
    // Base ticks per reference period, and the mask for the in-period count
    localparam logic [3:0] RCT_BASE_SPAN = 4'h8;
    localparam logic [2:0] RCT_BASE_MASK = 3'h7;
    // Multiplier as a shift: 0 is x1, 1 is x2, 2 is x4, 3 is not a legal code
    localparam logic [1:0] RCT_MULT_LOG_NORMAL = 2'h0;
    localparam logic [1:0] RCT_MULT_LOG_ALT = 2'h2;
    localparam logic [1:0] RCT_MULT_LOG_BAD = 2'h3;
    // Cycles spent in capture so the pin synchroniser has settled
    localparam logic [1:0] RCT_CAPTURE_CYCLES = 2'h3;
    localparam int unsigned RCT_FIFO_DEPTH = 32;

    typedef enum logic {
        RCT_ST_CAPTURE = 1'b0,
        RCT_ST_RUN = 1'b1
    } rct_state_t;
endpackage : rct_pkg

// >>> hw/rct_stream_if.sv
// Valid/ready word stream between the timing block and its FIFO.
// Assumes both ends sit on clk_sys.
`timescale 1ns/1ps
interface rct_stream_if #(parameter int unsigned WIDTH = 25);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : rct_stream_if

// >>> hw/rct_tick_div.sv
// Enable divider: one-cycle tick every DIV cycles of clk_sys.
// Assumes DIV of at least 2.
`timescale 1ns/1ps
module rct_tick_div #(
    parameter int unsigned DIV = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Tick
    output logic tick
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } rct_div_t;

    rct_div_t q;
    rct_div_t d;

    // Count up to the terminal value, tick registered
    always_comb
    begin
        d = q;
        d.tick = (q.cnt == LAST);
        d.cnt = (q.cnt == LAST) ? '0 : q.cnt + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;
endmodule : rct_tick_div

// >>> hw/rct_fifo.sv
// Word FIFO with valid/ready on both sides; honest full and empty.
// Assumes DEPTH is a power of two so pointers wrap naturally.
`timescale 1ns/1ps
module rct_fifo #(
    parameter int unsigned WIDTH = 25,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Streams
    rct_stream_if.snk in_s,
    rct_stream_if.src out_s
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } rct_fifo_t;

    rct_fifo_t q;
    rct_fifo_t d;
    logic push;
    logic pop;

    assign in_s.ready = (q.cnt != FULL_CNT);
    assign out_s.valid = (q.cnt != '0);
    assign out_s.data = q.mem[q.rd];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // Simultaneous push and pop keep the count; full refuses push
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wr] = in_s.data;
            d.wr = q.wr + 1'b1;
        end
        if (pop)
            d.rd = q.rd + 1'b1;
        if (push && !pop)
            d.cnt = q.cnt + 1'b1;
        else if (pop && !push)
            d.cnt = q.cnt - 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            q <= '0;
        else
            q <= d;
    end

    fifo_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        q.cnt <= FULL_CNT) else $error("fifo count beyond depth");
endmodule : rct_fifo

// >>> hw/rct_rx_timing.sv
// Receive timing: mode capture, clock derivation, sample and word pacing, channel tag.
// Assumes ADC words and settings arrive on clk_sys; mode and rate select are async pins.
`timescale 1ns/1ps
module rct_rx_timing #(
    parameter int unsigned DATA_W = 12,
    parameter int unsigned FIFO_DEPTH = rct_pkg::RCT_FIFO_DEPTH,
    parameter int unsigned BASE_DIV = rct_pkg::RCT_BASE_DIV
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Pins sampled asynchronously
    input wire logic timing_mode_pin,
    input wire logic rx_clock_rate_select,
    // Settings
    input wire logic sample_rate_halve,
    input wire logic rx_decimate,
    input wire logic rx_mux_enable,
    input wire logic rx_clock_invert,
    input wire logic rx_retime,
    input wire logic rx_tag_invert,
    input wire logic [1:0] dll_mult_sel,
    input wire logic dll_mult_load,
    // ADC words
    input wire logic [DATA_W-1:0] adc_data_a,
    input wire logic [DATA_W-1:0] adc_data_b,
    // Output flow control from the receiver
    input wire logic rx_out_hold,
    // Clocks out
    output logic rx_clock_out,
    output logic tx_clock_out,
    // Receive words
    output logic [DATA_W-1:0] rx_data_a,
    output logic [DATA_W-1:0] rx_data_b,
    output logic rx_channel_tag,
    output logic rx_word_strobe,
    // Status
    output logic adc_sample_strobe,
    output logic alt_mode_active,
    output logic rx_overrun,
    output logic rx_config_error
);
    localparam int unsigned FW = 2 * DATA_W + 1;

    typedef struct packed {
        rct_pkg::rct_state_t state;
        logic [1:0] cap_cnt;
        logic mode_m;
        logic mode_s;
        logic rsel_m;
        logic rsel_s;
        logic alt;
        logic [1:0] mult_log;
        logic [2:0] base_cnt;
        logic rx_div;
        logic rx_raw;
        logic rx_pin;
        logic tx_clk;
        logic [5:0] samp_cnt;
        logic dec_ph;
        logic [5:0] word_cnt;
        logic b_pend;
        logic [DATA_W-1:0] b_hold;
        logic hold_valid;
        logic [FW-1:0] hold_word;
        logic [DATA_W-1:0] data_a;
        logic [DATA_W-1:0] data_b;
        logic is_a;
        logic tag;
        logic strobe;
        logic samp_pulse;
        logic overrun;
        logic cfg_err;
    } rct_top_t;

    rct_top_t q;
    rct_top_t d;

    logic base_tick;
    logic run;
    logic hr_tick;
    logic mult_tick;
    logic [2:0] mmask;
    logic mux_ok;
    logic mux_eff;
    logic [3:0] base_span;
    logic [5:0] samp_per;
    logic [5:0] word_per;
    logic samp_tick;
    logic word_tick;
    logic keep;

    rct_stream_if #(.WIDTH(FW)) push_s ();
    rct_stream_if #(.WIDTH(FW)) pop_s ();

    rct_tick_div #(.DIV(BASE_DIV)) u_div (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick(base_tick)
    );

    // Backlog between sample pacing and output pacing; hold stalls the drain
    rct_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_s(push_s.snk),
        .out_s(pop_s.src)
    );

    // Tick decoding; base ticks run at eight per reference period
    assign run = (q.state == rct_pkg::RCT_ST_RUN);
    assign hr_tick = run && base_tick && (q.base_cnt[1:0] == 2'h3);
    assign mmask = rct_pkg::RCT_BASE_MASK >> q.mult_log;
    assign mult_tick = run && base_tick && ((q.base_cnt & mmask) == mmask);

    // Mux is refused in the low-rate, full-sample, undecimated setup
    assign mux_ok = q.rsel_s || sample_rate_halve || rx_decimate;
    assign mux_eff = rx_mux_enable && mux_ok;

    // Sample period from reference or multiplier, word period from it
    assign base_span = q.alt ? (rct_pkg::RCT_BASE_SPAN >> q.mult_log) : rct_pkg::RCT_BASE_SPAN;
    assign samp_per = {2'h0, base_span} << sample_rate_halve;
    assign word_per = (samp_per << rx_decimate) >> mux_eff;
    assign samp_tick = run && base_tick && (q.samp_cnt == 6'h00);
    assign word_tick = run && base_tick && (q.word_cnt == 6'h00);
    assign keep = !rx_decimate || q.dec_ph;

    // All next-state logic; pushes and pops leave through the two streams
    always_comb
    begin
        logic [FW-1:0] out_word;
        logic out_load;
        out_word = '0;
        out_load = 1'b0;
        d = q;
        d.mode_m = timing_mode_pin;
        d.mode_s = q.mode_m;
        d.rsel_m = rx_clock_rate_select;
        d.rsel_s = q.rsel_m;
        d.strobe = 1'b0;
        d.samp_pulse = 1'b0;
        d.cfg_err = rx_mux_enable && !mux_ok;
        push_s.valid = 1'b0;
        push_s.data = '0;
        pop_s.ready = 1'b0;
        if (base_tick)
            d.base_cnt = q.base_cnt + 3'h1;

        // Mode capture waits for the synchroniser, then commits once
        case (q.state)
            rct_pkg::RCT_ST_CAPTURE:
            begin
                if (q.cap_cnt == rct_pkg::RCT_CAPTURE_CYCLES)
                begin
                    d.state = rct_pkg::RCT_ST_RUN;
                    d.alt = q.mode_s;
                    d.mult_log = q.mode_s ? rct_pkg::RCT_MULT_LOG_ALT : rct_pkg::RCT_MULT_LOG_NORMAL;
                end
                else
                    d.cap_cnt = q.cap_cnt + 2'h1;
            end
            rct_pkg::RCT_ST_RUN:
            begin
                // Reserved multiplier code is ignored rather than guessed
                if (dll_mult_load && dll_mult_sel != rct_pkg::RCT_MULT_LOG_BAD)
                    d.mult_log = dll_mult_sel;
            end
            default:
                d.state = rct_pkg::RCT_ST_CAPTURE;
        endcase

        // Transmit clock always follows the multiplier
        if (mult_tick)
            d.tx_clk = !q.tx_clk;

        // Receive clock from reference ticks only, never the multiplier
        if (hr_tick)
        begin
            if (q.rsel_s)
                d.rx_raw = !q.rx_raw;
            else
            begin
                d.rx_div = !q.rx_div;
                if (q.rx_div)
                    d.rx_raw = !q.rx_raw;
            end
        end
        d.rx_pin = d.rx_raw ^ rx_clock_invert;

        // Sample and word pacing counters
        if (run && base_tick)
        begin
            d.samp_cnt = (q.samp_cnt == 6'h00) ? samp_per - 6'h01 : q.samp_cnt - 6'h01;
            d.word_cnt = (q.word_cnt == 6'h00) ? word_per - 6'h01 : q.word_cnt - 6'h01;
        end

        // Capture samples; mux sends A now and B on the next cycle
        if (samp_tick)
        begin
            d.samp_pulse = 1'b1;
            d.dec_ph = !q.dec_ph;
            if (keep)
            begin
                push_s.valid = 1'b1;
                if (mux_eff)
                begin
                    push_s.data = {1'b1, adc_data_a, {DATA_W{1'b0}}};
                    d.b_pend = 1'b1;
                    d.b_hold = adc_data_b;
                end
                else
                    push_s.data = {1'b1, adc_data_a, adc_data_b};
                if (!push_s.ready)
                    d.overrun = 1'b1;
            end
        end
        else if (q.b_pend)
        begin
            push_s.valid = 1'b1;
            push_s.data = {1'b0, q.b_hold, {DATA_W{1'b0}}};
            d.b_pend = 1'b0;
            if (!push_s.ready)
                d.overrun = 1'b1;
        end

        // Retimed words wait for the next half-reference edge
        if (hr_tick && q.hold_valid)
        begin
            out_word = q.hold_word;
            out_load = 1'b1;
            d.hold_valid = 1'b0;
        end

        // Drain one word per word slot unless the receiver holds off
        if (word_tick && !rx_out_hold)
        begin
            pop_s.ready = 1'b1;
            if (pop_s.valid)
            begin
                if (rx_retime)
                begin
                    d.hold_valid = 1'b1;
                    d.hold_word = pop_s.data;
                end
                else
                begin
                    out_word = pop_s.data;
                    out_load = 1'b1;
                end
            end
        end

        // Word and its tag change together
        if (out_load)
        begin
            d.data_a = out_word[FW-2:DATA_W];
            d.data_b = out_word[DATA_W-1:0];
            d.is_a = out_word[FW-1];
            d.tag = out_word[FW-1] ^ rx_tag_invert;
            d.strobe = 1'b1;
        end
    end

    // Synchronous reset puts control back into capture
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            q <= '0;
        else
            q <= d;
    end

    assign rx_clock_out = q.rx_pin;
    assign tx_clock_out = q.tx_clk;
    assign rx_data_a = q.data_a;
    assign rx_data_b = q.data_b;
    assign rx_channel_tag = q.tag;
    assign rx_word_strobe = q.strobe;
    assign adc_sample_strobe = q.samp_pulse;
    assign alt_mode_active = q.alt;
    assign rx_overrun = q.overrun;
    assign rx_config_error = q.cfg_err;

    // Checks; the gap figures assume the default base divider of four
    sequence s_capture_end;
        q.state == rct_pkg::RCT_ST_CAPTURE && q.cap_cnt == rct_pkg::RCT_CAPTURE_CYCLES;
    endsequence

    sequence s_hr_run;
        hr_tick && q.rsel_s;
    endsequence

    mode_capture_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_capture_end |=> (q.alt == $past(q.mode_s)) && run)
        else $error("timing mode not taken from pin");

    alt_mult_four_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_capture_end ##0 q.mode_s |=> q.mult_log == rct_pkg::RCT_MULT_LOG_ALT)
        else $error("alternative mode multiplier not four");

    tx_follows_mult_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        mult_tick |=> tx_clock_out != $past(tx_clock_out))
        else $error("transmit clock missed a multiplier tick");

    rx_clk_full_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_hr_run |=> q.rx_raw != $past(q.rx_raw))
        else $error("receive clock not at full rate");

    rx_clk_invert_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rx_clock_out == (q.rx_raw ^ $past(rx_clock_invert)))
        else $error("receive clock invert wrong");

    sample_gap_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !run)
        samp_tick && !q.alt && !sample_rate_halve && !q.alt |-> ##32 samp_tick)
        else $error("normal sample period not one reference period");

    tag_polarity_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rx_word_strobe |-> rx_channel_tag == (q.is_a ^ $past(rx_tag_invert)))
        else $error("channel tag polarity wrong");

    mux_refused_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rx_mux_enable && !q.rsel_s && !sample_rate_halve && !rx_decimate |=> rx_config_error)
        else $error("forbidden mux not flagged");

    quarter_rate_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !run)
        word_tick && !q.alt && q.rsel_s && sample_rate_halve && rx_decimate && !rx_mux_enable
        |-> ##128 word_tick)
        else $error("word slot not a quarter of the output clock");

    mux_double_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !run)
        word_tick && !q.alt && q.rsel_s && !sample_rate_halve && !rx_decimate && rx_mux_enable
        |-> ##16 word_tick)
        else $error("muxed word slot not twice the output clock");

    rx_clk_half_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        hr_tick && !q.rsel_s |=> q.rx_raw == ($past(q.rx_raw) ^ $past(q.rx_div)))
        else $error("receive clock not at half rate");

    mult_code_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        run && dll_mult_load && dll_mult_sel == rct_pkg::RCT_MULT_LOG_BAD |=> q.mult_log == $past(q.mult_log))
        else $error("reserved multiplier code was taken");

    retime_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rx_word_strobe && $past(rx_retime) |-> $past(hr_tick))
        else $error("retimed word not on a half-reference edge");
endmodule : rct_rx_timing

// >>> testbench/rct_asic_model.sv
// Model of the receiving logic that latches words from the timing block.
// Assumes it shares clk_sys with the block and stalls only when the bench asks.
`timescale 1ns/1ps
module rct_asic_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Words from the block
    input wire logic rx_word_strobe,
    input wire logic rx_channel_tag,
    input wire logic rx_tag_invert,
    // Flow control
    input wire logic stall,
    output logic rx_out_hold,
    // Latched results
    output logic last_is_a,
    output logic [15:0] word_count
);
    // Stall is passed straight through so no word is drained while the bus is held
    assign rx_out_hold = stall;

    // Latch on each strobe; only the tag tells which channel arrived
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            word_count <= 16'h0000;
            last_is_a <= 1'b0;
        end
        else if (rx_word_strobe)
        begin
            word_count <= word_count + 16'h0001;
            last_is_a <= rx_channel_tag ^ rx_tag_invert;
        end
    end
endmodule : rct_asic_model

// >>> testbench/rct_rx_timing_tb.sv
// Self-checking bench for the receive timing block with its receiving partner.
// Assumes 100 MHz clk_sys and BASE_DIV of 4, so one reference period is 32 cycles.
`timescale 1ns/1ps
module rct_rx_timing_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic mode_pin = 1'b0;
    logic rate_sel = 1'b0;
    logic halve = 1'b0;
    logic decim = 1'b0;
    logic mux = 1'b0;
    logic clk_inv = 1'b0;
    logic retime = 1'b0;
    logic tag_inv = 1'b0;
    logic [1:0] mult_sel = 2'h0;
    logic mult_load = 1'b0;
    logic stall = 1'b0;
    logic [11:0] adc_a = 12'hA5A;
    logic [11:0] adc_b = 12'h5B5;
    logic hold, rx_clk, tx_clk, tag, wstb, sstb, alt, ovr, cfg_err, last_a;
    logic [11:0] da, db;
    logic [15:0] wcnt;
    int unsigned n_fail = 0;
    int unsigned n_compared = 0;
    int unsigned cyc = 0;
    // Edge monitor: 0 rx clock, 1 tx clock, 2 sample strobe, 3 word strobe
    wire [3:0] mon = {wstb, sstb, tx_clk, rx_clk};

    // Clock generator
    always #5 clk_sys = ~clk_sys;

    // Device under test and its receiving partner
    rct_rx_timing dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .timing_mode_pin(mode_pin),
        .rx_clock_rate_select(rate_sel), .sample_rate_halve(halve), .rx_decimate(decim),
        .rx_mux_enable(mux), .rx_clock_invert(clk_inv), .rx_retime(retime),
        .rx_tag_invert(tag_inv), .dll_mult_sel(mult_sel), .dll_mult_load(mult_load),
        .adc_data_a(adc_a), .adc_data_b(adc_b), .rx_out_hold(hold),
        .rx_clock_out(rx_clk), .tx_clock_out(tx_clk), .rx_data_a(da), .rx_data_b(db),
        .rx_channel_tag(tag), .rx_word_strobe(wstb), .adc_sample_strobe(sstb),
        .alt_mode_active(alt), .rx_overrun(ovr), .rx_config_error(cfg_err)
    );
    rct_asic_model partner (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .rx_word_strobe(wstb), .rx_channel_tag(tag),
        .rx_tag_invert(tag_inv), .stall(stall), .rx_out_hold(hold), .last_is_a(last_a),
        .word_count(wcnt)
    );

    // Hang guard; the full run needs well under a third of this
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_fail++;
            results();
        end
    end

    // Inputs move 1 ns after the edge, so sampling there sees settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask : chk

    // Waits for the next rise of a monitored signal, bounded so a dead output fails
    task automatic rise(input int i, inout logic [31:0] n);
        logic p;
        do
        begin
            p = mon[i];
            tick(1);
            n++;
        end while (!(mon[i] && !p) && n < 3000);
    endtask : rise

    // Cycles between two rises; the first rise only aligns
    task automatic gap(input int i, output logic [31:0] g);
        g = 0;
        rise(i, g);
        g = 0;
        rise(i, g);
    endtask : gap

    task automatic do_reset(input logic m);
        sys_rst = 1'b1;
        mode_pin = m;
        {rate_sel, halve, decim, mux, retime, clk_inv, tag_inv} = 7'h00;
        tick(16);
        sys_rst = 1'b0;
        tick(8);
    endtask : do_reset

    task automatic load(input logic [1:0] s);
        mult_sel = s;
        mult_load = 1'b1;
        tick(1);
        mult_load = 1'b0;
        tick(1);
    endtask : load

    task automatic t_mode_alt();
        logic [31:0] g;
        do_reset(1'b1);
        chk("alt_mode_active", 1, alt);
        gap(1, g);
        chk("tx period default", 16, g);
        gap(2, g);
        chk("sample gap alt", 8, g);
        rate_sel = 1'b1;
        tick(40);
        gap(0, g);
        chk("rx clock period alt", 32, g);
        load(2'h0);
        gap(1, g);
        gap(1, g);
        chk("tx period x1 alt", 64, g);
    endtask : t_mode_alt

    task automatic t_mode_normal();
        logic [31:0] g;
        do_reset(1'b0);
        chk("alt_mode_active", 0, alt);
        gap(1, g);
        chk("tx period x1", 64, g);
        load(2'h2);
        gap(1, g);
        gap(1, g);
        chk("tx period x4", 16, g);
        load(2'h3);
        gap(1, g);
        chk("tx period after bad code", 16, g);
        gap(0, g);
        chk("rx clock period x4", 64, g);
        load(2'h1);
        gap(1, g);
        gap(1, g);
        chk("tx period x2", 32, g);
    endtask : t_mode_normal

    // Rows: {rate select, halve, decimate, mux, retime} and word gap in cycles
    task automatic t_rates();
        logic [31:0] g;
        logic [4:0] c [8] = '{5'h00, 5'h1C, 5'h12, 5'h18, 5'h16, 5'h1E, 5'h14, 5'h11};
        int unsigned wg [8] = '{32, 128, 16, 64, 32, 64, 64, 32};
        for (int k = 0; k < 8; k++)
        begin
            {rate_sel, halve, decim, mux, retime} = c[k];
            tick(400);
            gap(3, g);
            chk("word gap", wg[k], g);
            gap(2, g);
            chk("sample gap", 32 << halve, g);
            gap(0, g);
            chk("rx clock period", rate_sel ? 32 : 64, g);
        end
    endtask : t_rates

    task automatic t_tag(input logic inv);
        logic [31:0] g;
        logic [11:0] prev;
        {rate_sel, halve, decim, mux, retime} = 5'h12;
        tag_inv = inv;
        // Long enough for every older word in the FIFO to be replaced by muxed ones
        tick(600);
        prev = 12'h000;
        repeat (4)
        begin
            // One strobe per pass, so consecutive words are compared
            g = 0;
            rise(3, g);
            chk("channel tag", (da == adc_a) ? !inv : inv, tag);
            chk("mux alternates", 1, da != prev);
            prev = da;
            tick(1);
            chk("partner channel", da == adc_a, last_a);
        end
    endtask : t_tag

    task automatic t_cfg_err();
        logic [31:0] g;
        {rate_sel, halve, decim, mux, retime, tag_inv} = 6'h04;
        tick(100);
        chk("config error", 1, cfg_err);
        gap(3, g);
        chk("forbidden mux word gap", 32, g);
        mux = 1'b0;
    endtask : t_cfg_err

    task automatic t_clk_inv();
        logic [31:0] g;
        rate_sel = 1'b1;
        tick(100);
        g = 0;
        rise(0, g);
        tick(2);
        clk_inv = 1'b1;
        tick(2);
        chk("inverted rx clock", 0, rx_clk);
        gap(0, g);
        chk("inverted rx clock period", 32, g);
        clk_inv = 1'b0;
    endtask : t_clk_inv

    task automatic t_overrun();
        logic [31:0] g;
        logic [15:0] w0;
        rate_sel = 1'b0;
        // Settle past a full FIFO turnover so no muxed word is left behind
        tick(1100);
        stall = 1'b1;
        tick(2);
        w0 = wcnt;
        tick(1300);
        chk("words while held", w0, wcnt);
        chk("overrun", 1, ovr);
        stall = 1'b0;
        gap(3, g);
        chk("drain gap", 32, g);
        chk("channel a data", adc_a, da);
        chk("channel b data", adc_b, db);
        chk("unmuxed tag", 1, tag);
    endtask : t_overrun

    task automatic results();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // Main sequence
    initial
    begin
        t_mode_alt();
        t_mode_normal();
        t_rates();
        t_tag(1'b0);
        t_tag(1'b1);
        t_cfg_err();
        t_clk_inv();
        t_overrun();
        results();
    end
endmodule : rct_rx_timing_tb
